//--- core/ident_defines.svh
// Constants for the processor identification unit: bit positions, codes and reset values.
`ifndef IDENT_DEFINES_SVH
`define IDENT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Flags word bit positions
// ----------------------------------------------------------------------------
`define FLAGS_IO_PRIVILEGE_FIELD_LO 12
`define FLAGS_IO_PRIVILEGE_FIELD_HI 13
`define FLAGS_NT 14
`define FLAGS_RSVD15 15
`define FLAGS_AC 18
`define FLAGS_ID 21
`define FLAGS_RESET 32'h00000000

// ----------------------------------------------------------------------------
// Identify leaves and answers
// ----------------------------------------------------------------------------
`define LEAF_VENDOR 32'h00000000
`define LEAF_FEATURES 32'h00000001
`define LEAF_CACHE 32'h00000002
`define MAX_LEAF_OLD 32'h00000001
`define MAX_LEAF_NEW 32'h00000002
// Vendor string words; the values are arbitrary.
`define VENDOR_WORD_B 32'h706D6178
`define VENDOR_WORD_D 32'h6F43656C
`define VENDOR_WORD_C 32'h58657260
// Family, model and stepping codes; the values are arbitrary.
`define FAMILY_OLD 4'h4
`define FAMILY_NEW 4'h6
`define MODEL_ID 4'h1
`define STEPPING_ID 4'h0
`define CACHE_DESC 32'h00000001

// ----------------------------------------------------------------------------
// Feature flag positions in result register d
// ----------------------------------------------------------------------------
`define FEAT_FPU 0
`define FEAT_TSC 1
`define FEAT_MSR 2
`define FEAT_CX8 3
`define FEAT_APIC 4
`define FEAT_MTRR 5
`define FEAT_PGE 6
`define FEAT_CMOV 7
`define FEAT_CACHE 8

// ----------------------------------------------------------------------------
// Floating-point unit values and strap settling
// ----------------------------------------------------------------------------
`define FPU_ABSENT_WORD 16'hFFFF
`define FPU_CTRL_INIT 16'h037F
`define FPU_STAT_INIT 16'h0000
`define INF_POS_TAG 8'h7F
`define INF_NEG_TAG 8'hFF
`define STRAP_SETTLE 2'h2

`endif

//--- core/ident_pkg.sv
// Types shared by the processor identification unit.
package ident_pkg;

    // Core generations, oldest first.
    typedef enum logic [2:0] {
        gen16_early,
        gen16_late,
        gen32_first,
        gen32_align,
        gen32_leaf1,
        gen32_leaf2
    } gen_type;

    // Whole state of the identification unit.
    typedef struct packed {
        logic [4:0] strap_s1;
        logic [4:0] strap_s2;
        logic [1:0] settle;
        logic captured;
        gen_type gen;
        logic fpu_present;
        logic fpu_newer;
        logic [31:0] flags;
        logic [31:0] flags_view;
        logic [31:0] res_a;
        logic [31:0] res_b;
        logic [31:0] res_c;
        logic [31:0] res_d;
        logic done;
        logic fault;
        logic [15:0] fpu_ctrl;
        logic [15:0] fpu_stat;
        logic [7:0] inf_pos;
        logic [7:0] inf_neg;
    } state_type;

endpackage

//--- core/identify_leaf_rom.sv
// Answer table of the identify instruction for each generation and leaf.
`timescale 1ns/1ps
`include "ident_defines.svh"

module identify_leaf_rom (
    // Request
    input wire ident_pkg::gen_type gen_i,
    input wire logic [31:0] leaf_i,
    // Answer
    output logic [31:0] general_reg_a_o,
    output logic [31:0] general_reg_b_o,
    output logic [31:0] general_reg_c_o,
    output logic [31:0] general_reg_d_o
);

    logic newest;
    logic [31:0] feat;

    // Features grow with generation; the newest adds the later extensions.
    always_comb begin
        newest = (gen_i == ident_pkg::gen32_leaf2);
        feat = 32'h00000000;
        feat[`FEAT_FPU] = 1'b1;
        feat[`FEAT_TSC] = 1'b1;
        feat[`FEAT_MSR] = 1'b1;
        feat[`FEAT_CX8] = 1'b1;
        feat[`FEAT_APIC] = newest;
        feat[`FEAT_MTRR] = newest;
        feat[`FEAT_PGE] = newest;
        feat[`FEAT_CMOV] = newest;
        feat[`FEAT_CACHE] = newest;
        general_reg_a_o = 32'h00000000;
        general_reg_b_o = 32'h00000000;
        general_reg_c_o = 32'h00000000;
        general_reg_d_o = 32'h00000000;
        if (leaf_i == `LEAF_VENDOR) begin
            general_reg_a_o = newest ? `MAX_LEAF_NEW : `MAX_LEAF_OLD;
            general_reg_b_o = `VENDOR_WORD_B;
            general_reg_d_o = `VENDOR_WORD_D;
            general_reg_c_o = `VENDOR_WORD_C;
        end else if (leaf_i == `LEAF_FEATURES) begin
            general_reg_a_o[11:8] = newest ? `FAMILY_NEW : `FAMILY_OLD;
            general_reg_a_o[7:4] = `MODEL_ID;
            general_reg_a_o[3:0] = `STEPPING_ID;
            general_reg_d_o = feat;
        end else if (leaf_i == `LEAF_CACHE && newest) begin
            general_reg_a_o = `CACHE_DESC;
        end
    end

endmodule

//--- core/processor_identification_unit.sv
// Processor identification unit: identify instruction, flags word probes and FPU detection.
// Functional notes
// - Identify takes leaf 0, 1 or 2 from register a, answers in a-d.
// - Leaf 0 reports highest leaf: 2 on newest generation, else 1.
// - Leaf 1 returns family, model and stepping numbers.
// - Leaf 1 returns feature flags; leaf 2 returns cache information on the newest generation.
// - Leaf 0 returns vendor string across b, d, c in that order.
// - Cores without identify raise the invalid opcode fault instead.
// - Earliest 16-bit generation reads flags bits 12 to 15 as set.
// - Later 16-bit generation in real mode reads bits 12 to 15 clear.
// - 32-bit real mode: bit 15 clear, bits 12 to 14 hold last value.
// - Protected mode: bit 15 clear, bit 14 held, privilege field needs privilege 0.
// - Alignment-check bit 18 is writable only on newer 32-bit generations.
// - Bit 21 is writable only where identify is implemented.
// - Older coprocessor encodes both infinities alike; newer encodes them apart.
// - In protected mode, privilege field write above privilege 0 is ignored without fault.
`timescale 1ns/1ps
`include "ident_defines.svh"

module processor_identification_unit (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Straps from pins
    input wire logic [2:0] gen_strap_i,
    input wire logic fpu_present_i,
    input wire logic fpu_newer_i,
    // Identify instruction
    input wire logic ident_req_i,
    input wire logic [31:0] general_reg_a_i,
    output logic ident_done_o,
    output logic invalid_opcode_fault_o,
    output logic [31:0] general_reg_a_o,
    output logic [31:0] general_reg_b_o,
    output logic [31:0] general_reg_c_o,
    output logic [31:0] general_reg_d_o,
    // Flags word
    input wire logic pop_flags_op_i,
    input wire logic [31:0] pop_data_i,
    input wire logic protected_mode_i,
    input wire logic [1:0] current_privilege_i,
    output logic [31:0] push_flags_o,
    // Floating-point unit
    input wire logic fpu_nowait_init_op_i,
    output logic [15:0] fpu_status_o,
    output logic [15:0] fpu_control_o,
    output logic [7:0] fpu_pos_inf_o,
    output logic [7:0] fpu_neg_inf_o
);

    // ------------------------------------------------------------------------
    // Generation decoding
    // ------------------------------------------------------------------------

    // True where the identify instruction exists.
    function automatic logic has_identify(input ident_pkg::gen_type g);
        has_identify = (g == ident_pkg::gen32_leaf1) || (g == ident_pkg::gen32_leaf2);
    endfunction

    // True on 16-bit generations.
    function automatic logic is_16bit(input ident_pkg::gen_type g);
        is_16bit = (g == ident_pkg::gen16_early) || (g == ident_pkg::gen16_late);
    endfunction

    // Maps a strap code to a generation; unused codes mean the newest.
    function automatic ident_pkg::gen_type strap_gen(input logic [2:0] code);
        strap_gen = ident_pkg::gen32_leaf2;
        if (code <= 3'h5) begin
            strap_gen = ident_pkg::gen_type'(code);
        end
    endfunction

    ident_pkg::state_type s_q;
    ident_pkg::state_type s_d;
    logic [31:0] rom_a;
    logic [31:0] rom_b;
    logic [31:0] rom_c;
    logic [31:0] rom_d;
    logic [31:0] wr;

    // ------------------------------------------------------------------------
    // Answer table
    // ------------------------------------------------------------------------

    // The table answers the leaf currently presented in register a.
    identify_leaf_rom u_rom (
        .gen_i(s_q.gen),
        .leaf_i(general_reg_a_i),
        .general_reg_a_o(rom_a),
        .general_reg_b_o(rom_b),
        .general_reg_c_o(rom_c),
        .general_reg_d_o(rom_d)
    );

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------

    // Straps settle, identify answers, flags writes and FPU init are all resolved here.
    always_comb begin
        s_d = s_q;
        wr = s_q.flags;
        s_d.strap_s1 = {gen_strap_i, fpu_present_i, fpu_newer_i};
        s_d.strap_s2 = s_q.strap_s1;
        if (!s_q.captured) begin
            if (s_q.settle == `STRAP_SETTLE) begin
                s_d.captured = 1'b1;
                s_d.gen = strap_gen(s_q.strap_s2[4:2]);
                s_d.fpu_present = s_q.strap_s2[1];
                s_d.fpu_newer = s_q.strap_s2[0];
            end else begin
                s_d.settle = s_q.settle + 2'h1;
            end
        end
        // Identify requests answer one cycle later, or fault on cores without it.
        s_d.done = 1'b0;
        s_d.fault = 1'b0;
        if (ident_req_i) begin
            if (has_identify(s_q.gen)) begin
                s_d.done = 1'b1;
                s_d.res_a = rom_a;
                s_d.res_b = rom_b;
                s_d.res_c = rom_c;
                s_d.res_d = rom_d;
            end else begin
                s_d.fault = 1'b1;
            end
        end
        // Pop-flags writes obey the per-generation write policy.
        if (pop_flags_op_i) begin
            wr = pop_data_i;
            if (protected_mode_i && current_privilege_i != 2'h0) begin
                wr[`FLAGS_IO_PRIVILEGE_FIELD_HI:`FLAGS_IO_PRIVILEGE_FIELD_LO] =
                    s_q.flags[`FLAGS_IO_PRIVILEGE_FIELD_HI:`FLAGS_IO_PRIVILEGE_FIELD_LO];
            end
            if (s_q.gen < ident_pkg::gen32_align) begin
                wr[`FLAGS_AC] = 1'b0;
            end
            if (!has_identify(s_q.gen)) begin
                wr[`FLAGS_ID] = 1'b0;
            end
            if (is_16bit(s_q.gen)) begin
                wr[31:16] = 16'h0000;
            end
            wr[`FLAGS_RSVD15] = 1'b0;
        end
        s_d.flags = wr;
        // Read view is built from the new value so the next push sees it.
        s_d.flags_view = wr;
        if (s_q.gen == ident_pkg::gen16_early) begin
            s_d.flags_view[15:12] = 4'hF;
        end else if (s_q.gen == ident_pkg::gen16_late && !protected_mode_i) begin
            s_d.flags_view[15:12] = 4'h0;
        end else begin
            s_d.flags_view[`FLAGS_RSVD15] = 1'b0;
        end
        // FPU init loads the words; an absent unit reads all ones.
        if (fpu_nowait_init_op_i && s_q.fpu_present) begin
            s_d.fpu_ctrl = `FPU_CTRL_INIT;
            s_d.fpu_stat = `FPU_STAT_INIT;
            s_d.inf_pos = `INF_POS_TAG;
            s_d.inf_neg = s_q.fpu_newer ? `INF_NEG_TAG : `INF_POS_TAG;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // All state resets to constants; straps are caught after release.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.flags <= `FLAGS_RESET;
            s_q.flags_view <= `FLAGS_RESET;
            s_q.fpu_ctrl <= `FPU_ABSENT_WORD;
            s_q.fpu_stat <= `FPU_ABSENT_WORD;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign ident_done_o = s_q.done;
    assign invalid_opcode_fault_o = s_q.fault;
    assign general_reg_a_o = s_q.res_a;
    assign general_reg_b_o = s_q.res_b;
    assign general_reg_c_o = s_q.res_c;
    assign general_reg_d_o = s_q.res_d;
    assign push_flags_o = s_q.flags_view;
    assign fpu_status_o = s_q.fpu_stat;
    assign fpu_control_o = s_q.fpu_ctrl;
    assign fpu_pos_inf_o = s_q.inf_pos;
    assign fpu_neg_inf_o = s_q.inf_neg;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    logic stable_gen;
    assign stable_gen = s_q.captured;

    chk_fault_no_ident: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ident_req_i && !has_identify(s_q.gen) |=> invalid_opcode_fault_o && !ident_done_o)
        else $error("Missing fault on identify.");

    chk_done_ident: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ident_req_i && has_identify(s_q.gen) |=> ident_done_o && !invalid_opcode_fault_o)
        else $error("Missing identify answer.");

    chk_max_leaf: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ident_req_i && has_identify(s_q.gen) && general_reg_a_i == `LEAF_VENDOR |=>
        general_reg_a_o == ((s_q.gen == ident_pkg::gen32_leaf2) ? `MAX_LEAF_NEW
        : `MAX_LEAF_OLD))
        else $error("Wrong highest leaf.");

    chk_vendor_order: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ident_req_i && has_identify(s_q.gen) && general_reg_a_i == `LEAF_VENDOR |=>
        general_reg_b_o == `VENDOR_WORD_B && general_reg_d_o == `VENDOR_WORD_D
        && general_reg_c_o == `VENDOR_WORD_C)
        else $error("Vendor words out of order.");

    chk_early_bits_set: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        stable_gen && $past(stable_gen) && s_q.gen == ident_pkg::gen16_early
        |-> push_flags_o[15:12] == 4'hF)
        else $error("Early flags bits not set.");

    chk_late_bits_clr: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        stable_gen && s_q.gen == ident_pkg::gen16_late && !protected_mode_i
        |=> push_flags_o[15:12] == 4'h0)
        else $error("Late flags bits not clear.");

    chk_io_privilege_field_guard: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        stable_gen && s_q.gen != ident_pkg::gen16_early && pop_flags_op_i
        && protected_mode_i && current_privilege_i != 2'h0
        |=> push_flags_o[13:12] == $past(s_q.flags[13:12]))
        else $error("Privilege field changed above privilege 0.");

    chk_align_fixed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        stable_gen && s_q.gen < ident_pkg::gen32_align |=> push_flags_o[`FLAGS_AC] == 1'b0)
        else $error("Alignment bit moved on old core.");

    chk_id_toggle: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        stable_gen && pop_flags_op_i |=>
        push_flags_o[`FLAGS_ID] == ($past(pop_data_i[`FLAGS_ID]) && has_identify(s_q.gen)))
        else $error("Query bit write policy broken.");

    chk_pop_visible: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        pop_flags_op_i |=> push_flags_o[11:0] == $past(pop_data_i[11:0]))
        else $error("Popped value not visible.");

    chk_old_infinity: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        fpu_nowait_init_op_i && s_q.fpu_present |=>
        (fpu_pos_inf_o == fpu_neg_inf_o) == !s_q.fpu_newer)
        else $error("Infinity encoding mismatch.");

endmodule

//--- testbench/tb_top.sv
// Self-checking testbench for the processor identification unit.
`timescale 1ns/1ps
`include "ident_defines.svh"

module tb_top;

    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [2:0] gen_strap_i = 3'h0;
    logic fpu_present_i = 1'b0;
    logic fpu_newer_i = 1'b0;
    logic ident_req_i = 1'b0;
    logic [31:0] general_reg_a_i = 32'h0;
    logic pop_flags_op_i = 1'b0;
    logic [31:0] pop_data_i = 32'h0;
    logic protected_mode_i = 1'b0;
    logic [1:0] current_privilege_i = 2'h0;
    logic fpu_nowait_init_op_i = 1'b0;
    logic ident_done_o, invalid_opcode_fault_o;
    logic [31:0] general_reg_a_o, general_reg_b_o, general_reg_c_o, general_reg_d_o;
    logic [31:0] push_flags_o;
    logic [15:0] fpu_status_o, fpu_control_o;
    logic [7:0] fpu_pos_inf_o, fpu_neg_inf_o;
    int n_mismatch = 0;
    int total_checks = 0;

    processor_identification_unit dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .gen_strap_i(gen_strap_i),
        .fpu_present_i(fpu_present_i), .fpu_newer_i(fpu_newer_i),
        .ident_req_i(ident_req_i), .general_reg_a_i(general_reg_a_i),
        .ident_done_o(ident_done_o), .invalid_opcode_fault_o(invalid_opcode_fault_o),
        .general_reg_a_o(general_reg_a_o), .general_reg_b_o(general_reg_b_o),
        .general_reg_c_o(general_reg_c_o), .general_reg_d_o(general_reg_d_o),
        .pop_flags_op_i(pop_flags_op_i), .pop_data_i(pop_data_i),
        .protected_mode_i(protected_mode_i), .current_privilege_i(current_privilege_i),
        .push_flags_o(push_flags_o), .fpu_nowait_init_op_i(fpu_nowait_init_op_i),
        .fpu_status_o(fpu_status_o), .fpu_control_o(fpu_control_o),
        .fpu_pos_inf_o(fpu_pos_inf_o), .fpu_neg_inf_o(fpu_neg_inf_o)
    );

    // ------------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------------
    // A 40 MHz clock.
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #200us;
        n_mismatch++;
        wrap_up();
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Resets with the given straps and waits until the straps are captured.
    task automatic do_reset(logic [2:0] gen, logic fp, logic fn);
        @(negedge mclk_i);
        resetn_i = 1'b0;
        gen_strap_i = gen;
        fpu_present_i = fp;
        fpu_newer_i = fn;
        protected_mode_i = 1'b0;
        current_privilege_i = 2'h0;
        repeat (5) @(negedge mclk_i);
        chk("reset done", 32'h0, {31'h0, ident_done_o});
        chk("reset fpu status", 32'h0000FFFF, {16'h0, fpu_status_o});
        resetn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask

    // Issues one identify request and leaves the answer cycle for checks.
    // The leading wait keeps a new request off the edge that lowered the last one.
    task automatic ident(logic [31:0] leaf);
        @(negedge mclk_i);
        ident_req_i = 1'b1;
        general_reg_a_i = leaf;
        @(negedge mclk_i);
        ident_req_i = 1'b0;
    endtask

    // Writes the flags word; the read view is due one cycle later.
    task automatic pop(logic [31:0] data);
        @(negedge mclk_i);
        pop_flags_op_i = 1'b1;
        pop_data_i = data;
        @(negedge mclk_i);
        pop_flags_op_i = 1'b0;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    // Newest generation: vendor leaf, back-to-back leaves 1 and 2, a leaf out of range.
    task automatic test_newest();
        do_reset(3'h5, 1'b1, 1'b1);
        ident(`LEAF_VENDOR);
        chk("done", 32'h1, {31'h0, ident_done_o});
        chk("max leaf", `MAX_LEAF_NEW, general_reg_a_o);
        chk("vendor b", `VENDOR_WORD_B, general_reg_b_o);
        chk("vendor d", `VENDOR_WORD_D, general_reg_d_o);
        chk("vendor c", `VENDOR_WORD_C, general_reg_c_o);
        @(negedge mclk_i);
        ident_req_i = 1'b1;
        general_reg_a_i = `LEAF_FEATURES;
        @(negedge mclk_i);
        general_reg_a_i = `LEAF_CACHE;
        chk("ident", {20'h0, `FAMILY_NEW, `MODEL_ID, `STEPPING_ID},
            {20'h0, general_reg_a_o[11:0]});
        chk("features", 32'h1FF, {23'h0, general_reg_d_o[8:0]});
        @(negedge mclk_i);
        ident_req_i = 1'b0;
        chk("done b2b", 32'h1, {31'h0, ident_done_o});
        chk("cache leaf", `CACHE_DESC, general_reg_a_o);
        @(negedge mclk_i);
        chk("done pulse", 32'h0, {31'h0, ident_done_o});
        ident(32'h3);
        chk("leaf 3 a", 32'h0, general_reg_a_o | general_reg_b_o);
        chk("leaf 3 cd", 32'h0, general_reg_c_o | general_reg_d_o);
    endtask

    // Previous generation: highest leaf 1, no newest-only features, leaf 2 answered with zero in a.
    task automatic test_leaf1_gen();
        do_reset(3'h4, 1'b1, 1'b0);
        ident(`LEAF_VENDOR);
        chk("max leaf old", `MAX_LEAF_OLD, general_reg_a_o);
        ident(`LEAF_FEATURES);
        chk("family old", {28'h0, `FAMILY_OLD}, {28'h0, general_reg_a_o[11:8]});
        chk("fpu flag", 32'h1, {31'h0, general_reg_d_o[`FEAT_FPU]});
        chk("new features", 32'h0, {27'h0, general_reg_d_o[8:4]});
        ident(`LEAF_CACHE);
        chk("leaf 2 old", 32'h0, general_reg_a_o);
    endtask

    // Cores without identify fault and leave the result registers alone.
    task automatic test_no_ident();
        for (int g = 0; g < 4; g++) begin
            do_reset(g[2:0], 1'b0, 1'b0);
            ident(`LEAF_VENDOR);
            chk("fault", 32'h1, {31'h0, invalid_opcode_fault_o});
            chk("no done", 32'h0, {31'h0, ident_done_o});
            chk("regs kept", 32'h0, general_reg_a_o | general_reg_b_o);
        end
    endtask

    // Flags word behaviour per generation, mode and privilege.
    task automatic test_flags();
        do_reset(3'h0, 1'b0, 1'b0);
        pop(32'h0);
        chk("early 15:12", 32'hF, {28'h0, push_flags_o[15:12]});
        do_reset(3'h1, 1'b0, 1'b0);
        pop(32'hFFFFFFFF);
        chk("late 15:12", 32'h0, {28'h0, push_flags_o[15:12]});
        do_reset(3'h2, 1'b0, 1'b0);
        pop(32'h0024F0A5);
        chk("first32 15:12", 32'h7, {28'h0, push_flags_o[15:12]});
        chk("first32 low", 32'h0A5, {20'h0, push_flags_o[11:0]});
        chk("first32 ac id", 32'h0, {30'h0, push_flags_o[21], push_flags_o[18]});
        pop(32'h0);
        chk("first32 clear", 32'h0, {28'h0, push_flags_o[15:12]});
        do_reset(3'h3, 1'b0, 1'b0);
        pop(32'h00240000);
        chk("align ac id", 32'h1, {30'h0, push_flags_o[21], push_flags_o[18]});
        do_reset(3'h4, 1'b0, 1'b0);
        pop(32'h00240000);
        chk("leaf1 ac id", 32'h3, {30'h0, push_flags_o[21], push_flags_o[18]});
        pop(32'h0);
        chk("leaf1 cleared", 32'h0, {30'h0, push_flags_o[21], push_flags_o[18]});
        protected_mode_i = 1'b1;
        current_privilege_i = 2'h3;
        pop(32'h0000F000);
        chk("prot low priv", 32'h4, {28'h0, push_flags_o[15:12]});
        current_privilege_i = 2'h0;
        pop(32'h0000B000);
        chk("prot priv 0", 32'h3, {28'h0, push_flags_o[15:12]});
        current_privilege_i = 2'h1;
        pop(32'h0000C000);
        chk("prot kept", 32'h7, {28'h0, push_flags_o[15:12]});
    endtask

    // Coprocessor detection and generation by infinity encodings.
    task automatic test_fpu();
        do_reset(3'h2, 1'b0, 1'b0);
        fpu_nowait_init_op_i = 1'b1;
        @(negedge mclk_i);
        fpu_nowait_init_op_i = 1'b0;
        chk("absent ctrl", 32'hFFFF, {16'h0, fpu_control_o});
        for (int n = 0; n < 2; n++) begin
            do_reset(3'h2, 1'b1, n[0]);
            chk("pre init pos", 32'h0, {24'h0, fpu_pos_inf_o});
            fpu_nowait_init_op_i = 1'b1;
            @(negedge mclk_i);
            fpu_nowait_init_op_i = 1'b0;
            chk("ctrl", {16'h0, `FPU_CTRL_INIT}, {16'h0, fpu_control_o});
            chk("stat", {16'h0, `FPU_STAT_INIT}, {16'h0, fpu_status_o});
            chk("pos inf", {24'h0, `INF_POS_TAG}, {24'h0, fpu_pos_inf_o});
            chk("neg inf", {24'h0, (n == 1) ? `INF_NEG_TAG : `INF_POS_TAG},
                {24'h0, fpu_neg_inf_o});
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        test_newest();
        test_leaf1_gen();
        test_no_ident();
        test_flags();
        test_fpu();
        wrap_up();
    end

endmodule
